// ===== core/odrs_debounce.sv
// execute pushbutton synchroniser and debouncer
`timescale 1ns/100ps
module odrs_debounce #(
  parameter int CYC = odrs_pkg::DEBOUNCE_CYC // cycles the pin must stay changed
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // asynchronous reset, high
  input wire logic btn_raw, // pushbutton pin, high while pressed
  output logic held, // clean level, high while pressed
  output logic released // one-cycle pulse on a clean release
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] CNT_END = CW'(CYC - 1);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic clean;
    logic rel;
    logic [CW-1:0] cnt;
  } odrs_db_t;

  odrs_db_t db_ff;
  odrs_db_t nxt_db;

  // a change counts only after it held for the whole settle time,
  // so contact bounce cannot make two releases out of one press
  always_comb begin
    nxt_db = db_ff;
    nxt_db.sync1 = btn_raw;
    nxt_db.sync2 = db_ff.sync1;
    nxt_db.rel = 1'b0;
    if (db_ff.sync2 == db_ff.clean) begin
      nxt_db.cnt = '0;
    end else if (db_ff.cnt == CNT_END) begin
      nxt_db.cnt = '0;
      nxt_db.clean = db_ff.sync2;
      nxt_db.rel = db_ff.clean;
    end else begin
      nxt_db.cnt = db_ff.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      db_ff <= '0;
    end else begin
      db_ff <= nxt_db;
    end
  end

  assign held = db_ff.clean;
  assign released = db_ff.rel;
endmodule : odrs_debounce

// ===== core/odrs_reload_seq.sv
// off-line reload sequencer: copies backup floppy volumes back onto the hard disk
`timescale 1ns/100ps
module odrs_reload_seq #(
  parameter int DEBOUNCE_CYC = odrs_pkg::DEBOUNCE_CYC, // button settle time in cycles
  parameter int BLINK_CYC = odrs_pkg::BLINK_CYC // half period of the error blink
) (
  input wire logic clk_sys, // system clock, 200 MHz
  input wire logic rst, // asynchronous reset, high
  input wire logic exec_btn, // execute pushbutton pin, high while pressed
  input wire logic [2:0] mode_sw, // mode switch pins
  input wire logic [2:0] class_sw, // class switch pins
  output odrs_pkg::odrs_op_t op_code, // work requested from the disk side
  output logic op_req, // one-cycle request strobe
  input wire logic op_done, // one-cycle answer strobe
  input wire logic op_hard, // answer: hard error
  input wire logic op_crc, // answer: CRC error, may be retried
  input wire logic op_ddm, // answer: sector had a deleted data mark
  input wire logic op_last, // answer: last sector of this volume
  input wire logic op_mismatch, // answer: verify compare failed
  input wire logic id_ok, // identifier answer: format valid
  input wire logic [7:0] id_vol, // identifier answer: volume number
  input wire logic [7:0] id_ver, // identifier answer: backup version
  output logic door_lock, // floppy door lock, high locks
  output logic [7:0] seg_digits, // two display digits, high nibble left
  output logic seg_lit, // digits lit; toggles while blinking
  output logic fault_lamp, // general fault lamp
  output logic flp_lamp, // floppy drive error lamp
  output logic hd_lamp, // hard disk error lamp
  output logic irq, // level interrupt
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata // read data, valid the cycle after reg_rd
);
  localparam int BW = $clog2(BLINK_CYC + 1);
  localparam logic [BW-1:0] BLINK_END = BW'(BLINK_CYC - 1);

  typedef struct packed {
    odrs_pkg::odrs_state_t state;
    logic [2:0] msync1;
    logic [2:0] msync2;
    logic [2:0] csync1;
    logic [2:0] csync2;
    odrs_pkg::odrs_op_t op_code;
    logic op_req;
    logic busy;
    logic [4:0] retry;
    logic cont;
    logic verify;
    logic ver_valid;
    logic [7:0] ver;
    logic [7:0] vol;
    logic last;
    logic [7:0] disp;
    logic blink;
    logic lit;
    logic [BW-1:0] blink_cnt;
    logic door;
    logic fault;
    logic flp_lamp;
    logic hd_lamp;
    logic [odrs_pkg::EV_W-1:0] status;
    logic [odrs_pkg::EV_W-1:0] mask;
    logic panel_en;
    logic irq;
    logic [31:0] rdata;
  } odrs_seq_t;

  odrs_seq_t st_ff;
  odrs_seq_t nxt_st;
  logic btn_held;
  logic btn_rel;

  // switch setting that names a reload variant
  function automatic logic is_reload(input logic [2:0] m, input logic [2:0] c);
    return (m == odrs_pkg::MODE_RELOAD)
      && (c == odrs_pkg::CLASS_PLAIN || c == odrs_pkg::CLASS_VERIFY);
  endfunction : is_reload

  // register address match for a bus strobe
  function automatic logic hit(input logic stb, input logic [7:0] a, input logic [7:0] off);
    return stb && (a == off);
  endfunction : hit

  odrs_debounce #(
    .CYC(DEBOUNCE_CYC)
  ) u_btn (
    .clk_sys(clk_sys),
    .rst(rst),
    .btn_raw(exec_btn),
    .held(btn_held),
    .released(btn_rel)
  );

  // sequencer, display, lamps and register file in one next-state process
  always_comb begin
    odrs_pkg::odrs_op_t issue_op;
    logic issue;
    logic go_err;
    logic go_abort;
    logic hd_side;
    logic [7:0] err_code;
    logic [odrs_pkg::EV_W-1:0] ev;
    logic [odrs_pkg::EV_W-1:0] clr;
    issue_op = st_ff.op_code;
    issue = 1'b0;
    go_err = 1'b0;
    go_abort = 1'b0;
    hd_side = 1'b0;
    err_code = odrs_pkg::CODE_DONE;
    ev = '0;
    clr = '0;
    nxt_st = st_ff;
    nxt_st.msync1 = mode_sw;
    nxt_st.msync2 = st_ff.msync1;
    nxt_st.csync1 = class_sw;
    nxt_st.csync2 = st_ff.csync1;
    nxt_st.op_req = 1'b0;
    nxt_st.rdata = '0;

    // blink divider: digits stay lit unless an error code is shown
    if (st_ff.blink_cnt == BLINK_END) begin
      nxt_st.blink_cnt = '0;
      nxt_st.lit = ~st_ff.lit;
    end else begin
      nxt_st.blink_cnt = st_ff.blink_cnt + 1'b1;
    end
    if (!st_ff.blink) begin
      nxt_st.lit = 1'b1;
    end

    unique case (st_ff.state)
      odrs_pkg::ST_IDLE, odrs_pkg::ST_DONE, odrs_pkg::ST_ERR, odrs_pkg::ST_ABORT: begin
        // the panel is ignored while software has it switched off
        if (btn_held && st_ff.panel_en) begin
          nxt_st.state = odrs_pkg::ST_HELD;
          nxt_st.blink = 1'b0;
        end
      end
      odrs_pkg::ST_HELD: begin
        nxt_st.disp = {1'b0, st_ff.msync2, 1'b0, st_ff.csync2};
        if (btn_rel) begin
          if (is_reload(st_ff.msync2, st_ff.csync2)) begin
            nxt_st.state = odrs_pkg::ST_LOCK;
            nxt_st.door = 1'b1;
            nxt_st.verify = (st_ff.csync2 == odrs_pkg::CLASS_VERIFY);
            nxt_st.ver_valid = st_ff.cont && st_ff.ver_valid;
            nxt_st.fault = 1'b0;
            nxt_st.flp_lamp = 1'b0;
            nxt_st.hd_lamp = 1'b0;
            nxt_st.retry = '0;
          end else begin
            // any other setting hands the unit back to normal operation
            nxt_st.state = odrs_pkg::ST_IDLE;
            nxt_st.cont = 1'b0;
            nxt_st.door = 1'b0;
          end
        end
      end
      odrs_pkg::ST_LOCK: begin
        issue = 1'b1;
        issue_op = odrs_pkg::OP_ID;
        nxt_st.state = odrs_pkg::ST_ID;
      end
      odrs_pkg::ST_ID, odrs_pkg::ST_RD, odrs_pkg::ST_WR, odrs_pkg::ST_VF: begin
        hd_side = (st_ff.state == odrs_pkg::ST_WR);
        if (op_done && st_ff.busy) begin
          nxt_st.busy = 1'b0;
          if (op_hard) begin
            if (hd_side) begin
              go_abort = 1'b1;
              err_code = odrs_pkg::CODE_HD_WR;
            end else begin
              go_err = 1'b1;
              err_code = odrs_pkg::CODE_FLP_RD;
            end
          end else if (op_crc) begin
            if (st_ff.retry == odrs_pkg::CRC_RETRY_MAX) begin
              go_abort = 1'b1;
              err_code = odrs_pkg::CODE_CRC;
            end else begin
              nxt_st.retry = st_ff.retry + 1'b1;
              issue = 1'b1;
            end
          end else begin
            nxt_st.retry = '0;
            unique case (st_ff.state)
              odrs_pkg::ST_ID: begin
                if (!id_ok || (st_ff.ver_valid && id_ver != st_ff.ver)) begin
                  go_err = 1'b1;
                  err_code = odrs_pkg::CODE_BAD_ID;
                end else begin
                  nxt_st.vol = id_vol;
                  nxt_st.ver = id_ver;
                  nxt_st.ver_valid = 1'b1;
                  nxt_st.disp = id_vol;
                  issue = 1'b1;
                  issue_op = odrs_pkg::OP_FRD;
                  nxt_st.state = odrs_pkg::ST_RD;
                end
              end
              odrs_pkg::ST_RD: begin
                if (op_ddm) begin
                  // report, but the questionable data is still written
                  ev[odrs_pkg::EV_DDM] = 1'b1;
                  nxt_st.disp = odrs_pkg::CODE_DDM;
                  nxt_st.blink = 1'b1;
                  nxt_st.fault = 1'b1;
                  nxt_st.flp_lamp = 1'b1;
                end
                nxt_st.last = op_last;
                issue = 1'b1;
                issue_op = odrs_pkg::OP_HWR;
                nxt_st.state = odrs_pkg::ST_WR;
              end
              odrs_pkg::ST_WR: begin
                issue = !st_ff.last || st_ff.verify;
                issue_op = st_ff.last ? odrs_pkg::OP_CMP : odrs_pkg::OP_FRD;
                nxt_st.state = !st_ff.last ? odrs_pkg::ST_RD
                  : (st_ff.verify ? odrs_pkg::ST_VF : odrs_pkg::ST_DONE);
              end
              default: begin
                if (op_mismatch) begin
                  go_err = 1'b1;
                  err_code = odrs_pkg::CODE_CMP;
                end else if (op_last) begin
                  nxt_st.state = odrs_pkg::ST_DONE;
                end else begin
                  issue = 1'b1;
                  issue_op = odrs_pkg::OP_CMP;
                end
              end
            endcase
            if (nxt_st.state == odrs_pkg::ST_DONE && !go_err) begin
              nxt_st.door = 1'b0;
              nxt_st.disp = odrs_pkg::CODE_DONE;
              nxt_st.blink = 1'b0;
              nxt_st.cont = 1'b1;
              ev[odrs_pkg::EV_VOL_DONE] = 1'b1;
            end
          end
        end
      end
    endcase

    // error ends the volume: door opens so the operator can swap disks
    if (go_err || go_abort) begin
      nxt_st.state = go_abort ? odrs_pkg::ST_ABORT : odrs_pkg::ST_ERR;
      nxt_st.cont = go_err;
      nxt_st.door = 1'b0;
      nxt_st.disp = err_code;
      nxt_st.blink = 1'b1;
      nxt_st.fault = 1'b1;
      nxt_st.hd_lamp = st_ff.hd_lamp || hd_side;
      nxt_st.flp_lamp = st_ff.flp_lamp || !hd_side;
      ev[odrs_pkg::EV_ERROR] = 1'b1;
      ev[odrs_pkg::EV_ABORT] = go_abort;
    end

    // one request strobe per piece of work; the op code holds until the next
    if (issue) begin
      nxt_st.op_req = 1'b1;
      nxt_st.op_code = issue_op;
      nxt_st.busy = 1'b1;
    end

    // register writes; a new event beats a clear in the same cycle
    if (hit(reg_wr, reg_addr, odrs_pkg::ADDR_STATUS)) begin
      clr = reg_wdata[odrs_pkg::EV_W-1:0];
    end
    if (hit(reg_wr, reg_addr, odrs_pkg::ADDR_MASK)) begin
      nxt_st.mask = reg_wdata[odrs_pkg::EV_W-1:0];
    end
    if (hit(reg_wr, reg_addr, odrs_pkg::ADDR_CTRL)) begin
      nxt_st.panel_en = reg_wdata[0];
    end
    nxt_st.status = (st_ff.status & ~clr) | ev;
    nxt_st.irq = |(nxt_st.status & nxt_st.mask);

    // register reads; unmapped addresses read as zero
    if (hit(reg_rd, reg_addr, odrs_pkg::ADDR_STATUS)) begin
      nxt_st.rdata = 32'(st_ff.status);
    end else if (hit(reg_rd, reg_addr, odrs_pkg::ADDR_MASK)) begin
      nxt_st.rdata = 32'(st_ff.mask);
    end else if (hit(reg_rd, reg_addr, odrs_pkg::ADDR_CTRL)) begin
      nxt_st.rdata = 32'(st_ff.panel_en);
    end else if (hit(reg_rd, reg_addr, odrs_pkg::ADDR_STATE)) begin
      nxt_st.rdata = {16'h0000, st_ff.disp, st_ff.retry[3:0], st_ff.state};
    end else if (hit(reg_rd, reg_addr, odrs_pkg::ADDR_VOLUME)) begin
      nxt_st.rdata = {15'h0000, st_ff.ver_valid, st_ff.ver, st_ff.vol};
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.mask <= odrs_pkg::MASK_RST;
      st_ff.panel_en <= odrs_pkg::PANEL_EN_RST;
      st_ff.lit <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign op_code = st_ff.op_code;
  assign op_req = st_ff.op_req;
  assign door_lock = st_ff.door;
  assign seg_digits = st_ff.disp;
  assign seg_lit = st_ff.lit;
  assign fault_lamp = st_ff.fault;
  assign flp_lamp = st_ff.flp_lamp;
  assign hd_lamp = st_ff.hd_lamp;
  assign irq = st_ff.irq;
  assign reg_rdata = st_ff.rdata;

  // checks on the sequencer
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic answer_ok;
  assign answer_ok = op_done && st_ff.busy && !op_hard && !op_crc;

  sequence s_start;
    st_ff.state == odrs_pkg::ST_HELD && btn_rel && is_reload(st_ff.msync2, st_ff.csync2);
  endsequence
  sequence s_lock_then_id;
    door_lock ##1 (door_lock && op_req && op_code == odrs_pkg::OP_ID);
  endsequence
  property p_start;
    s_start |=> s_lock_then_id;
  endproperty

  a_show_switch: assert property (
    st_ff.state == odrs_pkg::ST_HELD && !btn_rel |=> st_ff.state == odrs_pkg::ST_HELD
      && seg_digits == {1'b0, $past(st_ff.msync2), 1'b0, $past(st_ff.csync2)})
    else $error("switch echo or early start while button held");
  a_lock_then_id: assert property (p_start)
    else $error("door not locked before identifier read");
  a_vol_shown: assert property (
    st_ff.state == odrs_pkg::ST_ID && answer_ok && id_ok && !st_ff.ver_valid
      |=> seg_digits == $past(id_vol) && op_req && op_code == odrs_pkg::OP_FRD)
    else $error("volume not shown or copy not started");
  a_done_zero: assert property (
    st_ff.state == odrs_pkg::ST_DONE |-> !door_lock && seg_digits == odrs_pkg::CODE_DONE)
    else $error("finished volume without unlock and 00");
  a_retry_keep: assert property (
    s_start and (st_ff.cont && st_ff.ver_valid) |=> st_ff.ver_valid ##1 st_ff.ver_valid)
    else $error("retry lost the backup set version");
  a_bad_id: assert property (
    st_ff.state == odrs_pkg::ST_ID && answer_ok && !id_ok
      |=> st_ff.state == odrs_pkg::ST_ERR && seg_digits == odrs_pkg::CODE_BAD_ID && !op_req)
    else $error("invalid identifier not refused");
  a_hd_abort: assert property (
    st_ff.state == odrs_pkg::ST_WR && op_done && st_ff.busy && op_hard
      |=> st_ff.state == odrs_pkg::ST_ABORT && !st_ff.cont && hd_lamp)
    else $error("hard disk write error did not abandon reload");
  a_fault_lamps: assert property (
    st_ff.state == odrs_pkg::ST_ERR || st_ff.state == odrs_pkg::ST_ABORT
      |-> fault_lamp && (flp_lamp || hd_lamp) && st_ff.blink && !door_lock)
    else $error("error shown without lamps or blink");
  a_ddm_goes_on: assert property (
    st_ff.state == odrs_pkg::ST_RD && answer_ok && op_ddm
      |=> seg_digits == odrs_pkg::CODE_DDM && op_req && op_code == odrs_pkg::OP_HWR)
    else $error("deleted data not reported as 45 or not written");
  a_crc_bound: assert property (
    (st_ff.retry <= odrs_pkg::CRC_RETRY_MAX)
      and (op_done && st_ff.busy && !op_hard && op_crc && st_ff.retry == odrs_pkg::CRC_RETRY_MAX
      |=> st_ff.state == odrs_pkg::ST_ABORT && seg_digits == odrs_pkg::CODE_CRC))
    else $error("CRC retries exceed limit");
  a_cmp_end: assert property (
    st_ff.state == odrs_pkg::ST_VF && answer_ok && op_mismatch
      |=> st_ff.state == odrs_pkg::ST_ERR && seg_digits == odrs_pkg::CODE_CMP && !op_req)
    else $error("verify mismatch not reported as 30");
  a_one_release: assert property (
    btn_rel |=> !btn_rel [*2])
    else $error("one press gave more than one release");
endmodule : odrs_reload_seq

// ===== pkg/odrs_pkg.sv
// package: constants, register map and types of the off-line reload sequencer
package odrs_pkg;
  // clock and panel timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int DEBOUNCE_NS = 10_000_000;
  localparam int BLINK_HALF_NS = 250_000_000;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLINK_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;

  // switch settings that select a reload, and the CRC retry limit
  localparam logic [2:0] MODE_RELOAD = 3'h6;
  localparam logic [2:0] CLASS_PLAIN = 3'h0;
  localparam logic [2:0] CLASS_VERIFY = 3'h1;
  localparam logic [4:0] CRC_RETRY_MAX = 5'h10;

  // two-digit display codes
  localparam logic [7:0] CODE_DONE = 8'h00;
  localparam logic [7:0] CODE_CMP = 8'h30;
  localparam logic [7:0] CODE_FLP_RD = 8'h41;
  localparam logic [7:0] CODE_BAD_ID = 8'h42;
  localparam logic [7:0] CODE_HD_WR = 8'h43;
  localparam logic [7:0] CODE_CRC = 8'h44;
  localparam logic [7:0] CODE_DDM = 8'h45;

  // register map, byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;
  localparam logic [7:0] ADDR_VOLUME = 8'h10;

  // event bits of status and mask
  localparam int EV_W = 4;
  localparam int EV_VOL_DONE = 0;
  localparam int EV_ERROR = 1;
  localparam int EV_DDM = 2;
  localparam int EV_ABORT = 3;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;
  localparam logic PANEL_EN_RST = 1'b1;

  // work handed to the disk side, one per request
  typedef enum logic [1:0] {
    OP_ID,
    OP_FRD,
    OP_HWR,
    OP_CMP
  } odrs_op_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_HELD,
    ST_LOCK,
    ST_ID,
    ST_RD,
    ST_WR,
    ST_VF,
    ST_DONE,
    ST_ERR,
    ST_ABORT
  } odrs_state_t;
endpackage : odrs_pkg

// ===== sim/odrs_disk_model.sv
// disk-side model: answers sequencer requests, with faults chosen by the bench
`timescale 1ns/100ps
module odrs_disk_model (
  input wire clk_sys, // system clock
  input wire rst, // reset, high
  input wire odrs_pkg::odrs_op_t op_code, // requested work
  input wire op_req, // request strobe
  output logic op_done, // answer strobe
  output logic op_hard, // hard error
  output logic op_crc, // crc error
  output logic op_ddm, // deleted data mark
  output logic op_last, // last sector
  output logic op_mismatch, // compare failed
  output logic id_ok, // identifier valid
  output logic [7:0] id_vol, // volume number
  output logic [7:0] id_ver, // backup version
  input wire logic [7:0] vol, // volume on the inserted disk
  input wire logic [7:0] ver, // backup version on the disk
  input wire logic [3:0] fault, // {bad id, deleted mark, mismatch, hard}
  input wire odrs_pkg::odrs_op_t hard_op, // operation that fails hard
  input wire logic [4:0] crc_n // crc answers before a clean read
);
  logic [4:0] f_ff;
  logic [3:0] wait_ff;
  logic [4:0] crc_ff;
  logic pend_ff;
  logic junk_ff;
  int n_id, n_frd, n_hwr, n_cmp, sec;
  // answer lines only mean something with op_done; else the flags toggle as noise and the identifier bytes read inverted
  assign {op_hard, op_crc, op_ddm, op_last, op_mismatch} = op_done ? f_ff : {5{junk_ff}};
  assign id_ok = op_done ? ~fault[3] : junk_ff;
  assign id_vol = op_done ? vol : ~vol;
  assign id_ver = op_done ? ver : ~ver;
  // latency follows the read count so answers come both prompt and slow
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {op_done, pend_ff, junk_ff, f_ff, wait_ff, crc_ff} <= '0;
      {n_id, n_frd, n_hwr, n_cmp, sec} <= '0;
    end else begin
      op_done <= 1'b0;
      junk_ff <= ~junk_ff;
      if (op_req) begin
        pend_ff <= 1'b1;
        wait_ff <= {2'h0, n_frd[1:0]} + 4'h1;
        case (op_code)
          odrs_pkg::OP_ID: begin
            n_id <= n_id + 1;
            {n_frd, n_hwr, n_cmp, sec} <= '0;
            crc_ff <= 5'h00;
          end
          odrs_pkg::OP_FRD: n_frd <= n_frd + 1;
          odrs_pkg::OP_HWR: n_hwr <= n_hwr + 1;
          default: n_cmp <= n_cmp + 1;
        endcase
      end else if (pend_ff && wait_ff > 4'h1) begin
        wait_ff <= wait_ff - 4'h1;
      end else if (pend_ff) begin
        pend_ff <= 1'b0;
        op_done <= 1'b1;
        f_ff <= 5'h00;
        if (fault[0] && op_code == hard_op) begin
          f_ff[4] <= 1'b1;
        end else if (op_code == odrs_pkg::OP_FRD && crc_ff < crc_n) begin
          f_ff[3] <= 1'b1;
          crc_ff <= crc_ff + 5'h01;
        end else if (op_code == odrs_pkg::OP_FRD) begin
          // two sectors a volume, the first may carry a deleted mark
          f_ff[2] <= fault[2] && sec == 0;
          f_ff[1] <= sec == 1;
          sec <= sec + 1;
        end else if (op_code == odrs_pkg::OP_CMP) begin
          f_ff[0] <= fault[1];
          f_ff[1] <= 1'b1;
        end
      end
    end
  end
endmodule : odrs_disk_model

// ===== sim/tb.sv
// testbench of the off-line reload sequencer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb;
  localparam int DB = 4;
  localparam int BL = 8;
  logic clk_sys, rst, exec_btn, reg_wr, reg_rd, seen;
  logic [2:0] mode_sw, class_sw;
  logic [7:0] reg_addr, vol, ver, watch, id_vol, id_ver, seg_digits;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] fault;
  logic [4:0] crc_n;
  odrs_pkg::odrs_op_t op_code, hard_op;
  logic op_req, op_done, op_hard, op_crc, op_ddm, op_last, op_mismatch, id_ok;
  logic door_lock, seg_lit, fault_lamp, flp_lamp, hd_lamp, irq;
  int n_errors = 0;
  int cmp_count = 0;
  odrs_reload_seq #(.DEBOUNCE_CYC(DB), .BLINK_CYC(BL)) DUT (.clk_sys, .rst, .exec_btn, .mode_sw,
    .class_sw, .op_code, .op_req, .op_done, .op_hard, .op_crc, .op_ddm, .op_last, .op_mismatch,
    .id_ok, .id_vol, .id_ver, .door_lock, .seg_digits, .seg_lit, .fault_lamp, .flp_lamp,
    .hd_lamp, .irq, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  odrs_disk_model dsk (.clk_sys, .rst, .op_code, .op_req, .op_done, .op_hard, .op_crc, .op_ddm,
    .op_last, .op_mismatch, .id_ok, .id_vol, .id_ver, .vol, .ver, .fault, .hard_op, .crc_n);
  task automatic final_report;
    $display("compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe, so sample right there
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 `CHK(nm, e, reg_rdata)
  endtask : rd
  // press, check the echo, release, then wait for the door to lock and free
  task automatic run(input logic [2:0] m, input logic [2:0] c, input logic rl);
    int i;
    wr(odrs_pkg::ADDR_STATUS, 32'hF);
    mode_sw <= m;
    class_sw <= c;
    exec_btn <= 1'b1;
    cyc(DB + 8);
    `CHK("held digits", {1'b0, m, 1'b0, c}, seg_digits)
    `CHK("held lock", 1'b0, door_lock)
    @(posedge clk_sys);
    exec_btn <= 1'b0;
    seen = 1'b0;
    for (i = 0; i < 40 && door_lock !== 1'b1; i++) cyc(1);
    `CHK("lock", rl, door_lock)
    for (i = 0; rl && i < 400 && door_lock !== 1'b0; i++) begin
      cyc(1);
      if (seg_digits === watch) seen = 1'b1;
    end
    if (i == 400) begin
      n_errors++;
      $display("MISMATCH wait exp unlock got timeout");
      final_report();
    end
  endtask : run
  // lp = {check drive lamps, floppy lamp, hard disk lamp}
  task automatic chk_err(input logic [7:0] code, input logic [2:0] lp);
    logic s0, s1;
    `CHK("err code", code, seg_digits)
    `CHK("fault lamp", 1'b1, fault_lamp)
    if (lp[2]) `CHK("drive lamps", lp[1:0], {flp_lamp, hd_lamp})
    {s0, s1} = 2'b00;
    repeat (2 * BL + 2) begin
      cyc(1);
      s0 |= seg_lit === 1'b0;
      s1 |= seg_lit === 1'b1;
    end
    `CHK("blink", 2'b11, {s0, s1})
  endtask : chk_err
  task automatic t_reset;
    `CHK("rst lit", 1'b1, seg_lit)
    `CHK("rst lock", 1'b0, door_lock)
    rd(odrs_pkg::ADDR_MASK, 32'h0, "mask");
    rd(odrs_pkg::ADDR_CTRL, 32'h1, "ctrl");
    rd(8'h20, 32'h0, "unmapped");
    $display("test reset done");
  endtask : t_reset
  task automatic t_plain;
    wr(odrs_pkg::ADDR_MASK, 32'h1);
    watch = 8'h03;
    run(3'h6, 3'h0, 1'b1);
    `CHK("vol shown", 1'b1, seen)
    `CHK("done code", odrs_pkg::CODE_DONE, seg_digits)
    `CHK("writes", 2, dsk.n_hwr)
    `CHK("no verify", 0, dsk.n_cmp)
    `CHK("one start", 1, dsk.n_id)
    cyc(1);
    `CHK("irq", 1'b1, irq)
    rd(odrs_pkg::ADDR_STATUS, 32'h1, "status");
    wr(odrs_pkg::ADDR_STATUS, 32'h1);
    cyc(1);
    `CHK("irq clear", 1'b0, irq)
    $display("test plain done");
  endtask : t_plain
  task automatic t_verify;
    fault = 4'h2;
    run(3'h6, 3'h1, 1'b1);
    chk_err(odrs_pkg::CODE_CMP, 3'h6);
    `CHK("compares", 1, dsk.n_cmp)
    fault = 4'h0;
    $display("test verify done");
  endtask : t_verify
  task automatic t_flp_hard;
    fault = 4'h1;
    hard_op = odrs_pkg::OP_FRD;
    run(3'h6, 3'h0, 1'b1);
    chk_err(odrs_pkg::CODE_FLP_RD, 3'h6);
    {fault, vol, watch} = {4'h0, 8'h05, 8'h05};
    run(3'h6, 3'h0, 1'b1);
    `CHK("next vol", 1'b1, seen)
    `CHK("retry done", odrs_pkg::CODE_DONE, seg_digits)
    rd(odrs_pkg::ADDR_VOLUME, 32'h00010105, "volume");
    $display("test floppy error done");
  endtask : t_flp_hard
  task automatic t_bad_id;
    fault = 4'h8;
    run(3'h6, 3'h0, 1'b1);
    chk_err(odrs_pkg::CODE_BAD_ID, 3'h0);
    `CHK("no copy", 0, dsk.n_frd)
    fault = 4'h0;
    run(3'h6, 3'h0, 1'b1);
    `CHK("swap done", 2, dsk.n_hwr)
    $display("test bad id done");
  endtask : t_bad_id
  task automatic t_ddm;
    {fault, watch} = {4'h4, odrs_pkg::CODE_DDM};
    run(3'h6, 3'h0, 1'b1);
    `CHK("ddm code", 1'b1, seen)
    `CHK("ddm writes", 2, dsk.n_hwr)
    `CHK("ddm lamp", 1'b1, fault_lamp)
    rd(odrs_pkg::ADDR_STATUS, 32'h5, "ddm status");
    fault = 4'h0;
    $display("test deleted data done");
  endtask : t_ddm
  task automatic t_crc;
    crc_n = 5'h10;
    run(3'h6, 3'h0, 1'b1);
    `CHK("crc reads", 18, dsk.n_frd)
    crc_n = 5'h11;
    run(3'h6, 3'h0, 1'b1);
    chk_err(odrs_pkg::CODE_CRC, 3'h0);
    `CHK("crc abort", 17, dsk.n_frd)
    crc_n = 5'h00;
    $display("test crc done");
  endtask : t_crc
  task automatic t_hd;
    fault = 4'h1;
    hard_op = odrs_pkg::OP_HWR;
    run(3'h6, 3'h0, 1'b1);
    chk_err(odrs_pkg::CODE_HD_WR, 3'h5);
    `CHK("one write", 1, dsk.n_hwr)
    rd(odrs_pkg::ADDR_STATUS, 32'hA, "abort status");
    `CHK("masked irq", 1'b0, irq)
    fault = 4'h0;
    $display("test write error done");
  endtask : t_hd
  task automatic t_ver;
    run(3'h6, 3'h0, 1'b1);
    ver = 8'h02;
    run(3'h6, 3'h0, 1'b1);
    chk_err(odrs_pkg::CODE_BAD_ID, 3'h0);
    `CHK("mixed set", 0, dsk.n_frd)
    ver = 8'h01;
    run(3'h0, 3'h0, 1'b0);
    `CHK("normal", 0, dsk.n_frd)
    rd(odrs_pkg::ADDR_STATE, 32'h0, "normal state");
    $display("test version done");
  endtask : t_ver
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    rst = 1'b1;
    {exec_btn, reg_wr, reg_rd, seen, fault, crc_n} = '0;
    {mode_sw, class_sw, reg_addr, reg_wdata} = '0;
    {vol, ver, watch} = {8'h03, 8'h01, 8'h00};
    hard_op = odrs_pkg::OP_ID;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_plain();
    t_verify();
    t_flp_hard();
    t_bad_id();
    t_ddm();
    t_crc();
    t_hd();
    t_ver();
    final_report();
  end
endmodule : tb
